// *** pkg/fsim_pkg.sv ***
/*
  constants and types for the fault, power-good and interrupt monitor:
  sub-addresses, field positions, reset values, write masks, time figures.
  assumes a 100 MHz system clock and a 1 us internal time base tick.
*/
package fsim_pkg;

  // register sub-addresses on the serial command port
  localparam logic [7:0] ADDR_WARN_CTRL  = 8'h00;  // uv/ot warning control
  localparam logic [7:0] ADDR_PG_LATCHED = 8'h01;  // latched power-good status
  localparam logic [7:0] ADDR_PG_LIVE    = 8'h02;  // live power-good status
  localparam logic [7:0] ADDR_PG_MASK    = 8'h03;  // power-good mask
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;  // interrupt status
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h05;  // interrupt mask
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h06;  // interrupt clear command
  localparam logic [7:0] ADDR_HARD_RESET = 8'h07;  // hard reset command

  // warning control fields
  localparam int unsigned UV_SEL_LSB = 2;  // falling uv warning level, bits 4:2
  localparam int unsigned UV_SEL_W   = 3;
  localparam int unsigned OT_SEL_LSB = 0;  // ot warning offset, bits 1:0
  localparam int unsigned OT_SEL_W   = 2;

  // interrupt status bit positions
  localparam int unsigned IRQ_HARD_RESET_COMMAND_BIT    = 1;
  localparam int unsigned IRQ_PG_TMO_BIT  = 2;
  localparam int unsigned IRQ_UV_WARN_BIT = 3;
  localparam int unsigned IRQ_UV_STBY_BIT = 4;
  localparam int unsigned IRQ_OT_WARN_BIT = 5;
  localparam int unsigned IRQ_OT_STBY_BIT = 6;

  // regulator count and used power-good bits (bit 4 unused)
  localparam int unsigned NUM_REG      = 8;
  localparam logic [7:0]  PG_USED_MASK = 8'hef;

  // reset values and writable bits
  localparam logic [7:0] WARN_CTRL_RST  = 8'h00;
  localparam logic [7:0] WARN_CTRL_WMSK = 8'hff;
  localparam logic [7:0] PG_MASK_RST    = 8'hef;
  localparam logic [7:0] PG_MASK_WMSK   = 8'hef;
  localparam logic [7:0] IRQ_MASK_RST   = 8'h00;
  localparam logic [7:0] IRQ_MASK_WMSK  = 8'h7c;
  localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
  localparam logic [7:0] IRQ_PIN_BITS   = 8'h7e;  // bits that may pull the pin
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  // time base
  localparam int unsigned CLK_NS   = 10;
  localparam int unsigned TICK_NS  = 1000;
  localparam int unsigned TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

  // intervals in their printed units, then in ticks
  localparam int unsigned FILTER_US  = 50;
  localparam int unsigned PERSIST_MS = 20;
  localparam int unsigned HOLD_MS    = 1;
  localparam int unsigned STARTUP_S  = 5;
  localparam int unsigned STANDBY_S  = 1;
  localparam int unsigned HARD_RESET_COMMAND_S     = 1;
  localparam int unsigned FILTER_TICKS  = FILTER_US * 1000 / (TICK_NS / 1);
  localparam int unsigned PERSIST_TICKS = PERSIST_MS * 1000000 / TICK_NS;
  localparam int unsigned HOLD_TICKS    = HOLD_MS * 1000000 / TICK_NS;
  localparam int unsigned STARTUP_TICKS = STARTUP_S * 1000000 / (TICK_NS / 1000);
  localparam int unsigned STANDBY_TICKS = STANDBY_S * 1000000 / (TICK_NS / 1000);
  localparam int unsigned HARD_RESET_COMMAND_TICKS    = HARD_RESET_COMMAND_S * 1000000 / (TICK_NS / 1000);
  localparam int unsigned CNT_W         = 32;

  // operating state controller
  typedef enum logic [1:0] {
    ST_POR,
    ST_ON,
    ST_STANDBY,
    ST_HARD_RESET_COMMAND_WAIT
  } fsim_state_type;

endpackage

// *** rtl/fsim_interval_timer.sv ***
/*
  interval timer: reports that a condition has held for LIMIT ticks.
  assumes tick_in is a one-cycle enable on the same clock as clk_in and
  cond_in is already synchronous to that clock.
*/
`timescale 1ns/10ps
module fsim_interval_timer
  import fsim_pkg::*;
#(
  parameter int unsigned LIMIT = 50
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  // time base and watched condition
  input  wire logic tick_in,
  input  wire logic cond_in,
  // condition has lasted the full interval
  output logic      expired_out
);

  logic [CNT_W-1:0] cnt_q;  // ticks counted while condition holds

  // count while condition holds, restart when it goes away
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= '0;
    end else if (!cond_in) begin
      cnt_q <= '0;
    end else if (tick_in && (cnt_q < CNT_W'(LIMIT))) begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // registered expiry flag
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      expired_out <= 1'b0;
    end else begin
      expired_out <= cond_in && (cnt_q >= CNT_W'(LIMIT));
    end
  end

endmodule

// *** rtl/fsim_monitor.sv ***
/*
  fault detection, power-good and interrupt reporting for a multi-rail
  power manager: supply undervoltage, die overtemperature, regulator
  output-low filtering, open-drain power-good, latched interrupt pin,
  status and mask registers and the operating state controller.
  assumes comparator and regulator levels arrive asynchronously, and the
  register port is driven by a serial command engine on sys_clk_in.
*/
`timescale 1ns/10ps
module fsim_monitor
  import fsim_pkg::*;
#(
  parameter int unsigned FILTER_LIM  = FILTER_TICKS,   // output-low filter
  parameter int unsigned PERSIST_LIM = PERSIST_TICKS,  // persistence timeout
  parameter int unsigned HOLD_LIM    = HOLD_TICKS,     // hold after recovery
  parameter int unsigned STARTUP_LIM = STARTUP_TICKS,  // rising supply timeout
  parameter int unsigned STANDBY_LIM = STANDBY_TICKS,  // standby interval
  parameter int unsigned HARD_RESET_COMMAND_LIM    = HARD_RESET_COMMAND_TICKS      // hard reset wait
) (
  // clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 arst_n_in,
  // register port from the serial command engine
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic                 reg_wr_in,
  input  wire logic [7:0]           reg_wdata_in,
  input  wire logic                 reg_rd_in,
  input  wire logic                 reg_cmd_in,
  output logic      [7:0]           reg_rdata_out,
  // regulator levels, asynchronous
  input  wire logic [NUM_REG-1:0]   reg_enabled_in,
  input  wire logic [NUM_REG-1:0]   reg_out_low_in,
  input  wire logic [NUM_REG-1:0]   reg_out_good_in,
  // supply and temperature comparators, asynchronous
  input  wire logic                 supply_undervoltage_in,
  input  wire logic                 supply_rise_ok_in,
  input  wire logic                 supply_uv_warn_in,
  input  wire logic                 die_overtemperature_in,
  input  wire logic                 die_ot_recovered_in,
  input  wire logic                 die_ot_warn_in,
  input  wire logic                 master_power_on_input_in,
  // comparator level selects
  output logic      [UV_SEL_W-1:0]  uv_warn_sel_out,
  output logic      [OT_SEL_W-1:0]  ot_warn_sel_out,
  // open-drain power-good pin
  output logic                      power_good_output_o_out,
  output logic                      power_good_output_oe_out,
  // active-low interrupt pin
  output logic                      irq_n_out,
  // state controller results
  output fsim_state_type            state_out,
  output logic                      enables_inhibit_out,
  output logic                      keepalive_clear_out,
  output logic                      cmd_defaults_out
);

  localparam int unsigned RAW_W = 3 * NUM_REG + 7;  // synchronised input bits

  // input synchronisers
  logic [RAW_W-1:0]   sync1_q;  // first stage, read only by second
  logic [RAW_W-1:0]   sync2_q;  // usable levels
  logic [NUM_REG-1:0] en_s;     // regulator enabled
  logic [NUM_REG-1:0] low_s;    // output below lower level
  logic [NUM_REG-1:0] good_s;   // output above upper level
  logic               uv_s;     // supply undervoltage fault
  logic               rise_s;   // supply above rising level
  logic               uvw_s;    // supply warning level crossed
  logic               ot_s;     // overtemperature trip
  logic               cool_s;   // below recovery temperature
  logic               otw_s;    // overtemperature warning
  logic               pwr_s;    // master power-on

  // two-stage synchroniser for all asynchronous levels
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {reg_enabled_in, reg_out_low_in, reg_out_good_in,
                  supply_undervoltage_in, supply_rise_ok_in, supply_uv_warn_in,
                  die_overtemperature_in, die_ot_recovered_in, die_ot_warn_in,
                  master_power_on_input_in};
      sync2_q <= sync1_q;
    end
  end

  assign {en_s, low_s, good_s, uv_s, rise_s, uvw_s, ot_s, cool_s, otw_s, pwr_s}
    = sync2_q;

  // time base divider
  logic [CNT_W-1:0] div_q;   // cycles within a tick
  logic             tick_q;  // one-cycle 1 us enable

  // single time base for every interval
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == CNT_W'(TICK_CYC - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + {{(CNT_W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end

  // command registers
  logic [7:0] ctrl_q;     // warning control
  logic [7:0] pg_mask_q;  // power-good mask
  logic [7:0] irq_mask_q; // interrupt mask
  logic       wr_hit;     // write strobe for command decode
  logic       clr_hit;    // any access to interrupt clear
  logic       hard_reset_command_hit;   // write or command access to hard reset, reads ignored

  assign wr_hit   = reg_wr_in;
  assign clr_hit  = (reg_wr_in || reg_rd_in || reg_cmd_in)
                    && (reg_addr_in == ADDR_IRQ_CLEAR);
  assign hard_reset_command_hit = (reg_wr_in || reg_cmd_in) && (reg_addr_in == ADDR_HARD_RESET);

  // command register writes, hard reset restores defaults
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q     <= WARN_CTRL_RST;
      pg_mask_q  <= PG_MASK_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (hard_reset_command_hit) begin
      ctrl_q     <= WARN_CTRL_RST;
      pg_mask_q  <= PG_MASK_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_hit) begin
      unique case (reg_addr_in)
        ADDR_WARN_CTRL: begin
          ctrl_q <= (reg_wdata_in & WARN_CTRL_WMSK) | (ctrl_q & ~WARN_CTRL_WMSK);
        end
        ADDR_PG_MASK: begin
          // unused bit keeps its value
          pg_mask_q <= (reg_wdata_in & PG_MASK_WMSK) | (pg_mask_q & ~PG_MASK_WMSK);
        end
        ADDR_IRQ_MASK: begin
          irq_mask_q <= (reg_wdata_in & IRQ_MASK_WMSK)
                        | (irq_mask_q & ~IRQ_MASK_WMSK);
        end
        default: begin
          ctrl_q <= ctrl_q;  // status and command addresses store nothing
        end
      endcase
    end
  end

  // warning level selects straight from the control register
  assign uv_warn_sel_out = ctrl_q[UV_SEL_LSB +: UV_SEL_W];
  assign ot_warn_sel_out = ctrl_q[OT_SEL_LSB +: OT_SEL_W];

  // per-regulator output-low filtering
  logic [NUM_REG-1:0] cond_low;   // enabled and below lower level
  logic [NUM_REG-1:0] filt_exp;   // low past the filter time
  logic [NUM_REG-1:0] pers_exp;   // low past the persistence time
  logic [NUM_REG-1:0] hold_exp;   // recovered for the hold time
  logic [NUM_REG-1:0] held_q;     // reported low, includes hold
  logic [NUM_REG-1:0] live_q;     // live status, 1 good
  logic [NUM_REG-1:0] pers_d1_q;  // persistence history for edge

  assign cond_low = en_s & low_s;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REG; gi++) begin : g_reg
      if (PG_USED_MASK[gi]) begin : g_used
        // filter short dips
        fsim_interval_timer #(.LIMIT(FILTER_LIM)) u_filter (
          .clk_in      (sys_clk_in),
          .arst_n_in   (arst_n_in),
          .tick_in     (tick_q),
          .cond_in     (cond_low[gi]),
          .expired_out (filt_exp[gi])
        );
        // persistent low condition
        fsim_interval_timer #(.LIMIT(PERSIST_LIM)) u_persist (
          .clk_in      (sys_clk_in),
          .arst_n_in   (arst_n_in),
          .tick_in     (tick_q),
          .cond_in     (cond_low[gi]),
          .expired_out (pers_exp[gi])
        );
        // hold interval after recovery
        fsim_interval_timer #(.LIMIT(HOLD_LIM)) u_hold (
          .clk_in      (sys_clk_in),
          .arst_n_in   (arst_n_in),
          .tick_in     (tick_q),
          .cond_in     (held_q[gi] && !cond_low[gi]),
          .expired_out (hold_exp[gi])
        );

        // latched low report, held until condition gone plus hold time
        always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
          if (!arst_n_in) begin
            held_q[gi] <= 1'b0;
          end else if (filt_exp[gi]) begin
            held_q[gi] <= 1'b1;
          end else if (hold_exp[gi]) begin
            held_q[gi] <= 1'b0;
          end
        end

        // live status follows the condition only
        always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
          if (!arst_n_in) begin
            live_q[gi] <= 1'b1;
          end else begin
            live_q[gi] <= !cond_low[gi];
          end
        end
      end else begin : g_unused
        // unused position reads as zero, never pulls
        assign filt_exp[gi] = 1'b0;
        assign pers_exp[gi] = 1'b0;
        assign hold_exp[gi] = 1'b0;
        assign held_q[gi]   = 1'b0;
        assign live_q[gi]   = 1'b0;
      end
    end
  endgenerate

  // status bytes: 1 good, unused bit 0, mask never applied
  logic [7:0] pg_latched;  // latched power-good status
  logic [7:0] pg_live;     // live power-good status
  assign pg_latched = ~held_q & PG_USED_MASK;
  assign pg_live    = live_q & PG_USED_MASK;

  // power-good pin pull-down decision
  logic pg_pull_d;  // pin must be pulled low
  assign pg_pull_d = (~|(en_s & PG_USED_MASK))
                     || (|(en_s & ~good_s & PG_USED_MASK))
                     || (|(held_q & pg_mask_q & PG_USED_MASK));

  // open-drain pin: output fixed low, enable when pulling
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      power_good_output_o_out  <= 1'b0;
      power_good_output_oe_out <= 1'b1;
    end else begin
      power_good_output_o_out  <= 1'b0;
      power_good_output_oe_out <= pg_pull_d;
    end
  end

  // overtemperature fault with recovery hysteresis
  logic ot_fault_q;  // fault stands until cool
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ot_fault_q <= 1'b0;
    end else if (ot_s) begin
      ot_fault_q <= 1'b1;
    end else if (cool_s) begin
      ot_fault_q <= 1'b0;
    end
  end

  // event edge history
  logic uv_d1_q;    // supply fault history
  logic uvw_d1_q;   // supply warning history
  logic ot_d1_q;    // ot fault history
  logic otw_d1_q;   // ot warning history
  logic hard_reset_command_evt;   // hard reset accepted this cycle

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      uv_d1_q   <= 1'b0;
      uvw_d1_q  <= 1'b0;
      ot_d1_q   <= 1'b0;
      otw_d1_q  <= 1'b0;
      pers_d1_q <= '0;
    end else begin
      uv_d1_q   <= uv_s;
      uvw_d1_q  <= uvw_s;
      ot_d1_q   <= ot_fault_q;
      otw_d1_q  <= otw_s;
      pers_d1_q <= pers_exp;
    end
  end

  // event set vector in status bit positions
  logic [7:0] irq_set;
  always_comb begin
    irq_set                  = 8'h00;
    irq_set[IRQ_HARD_RESET_COMMAND_BIT]    = hard_reset_command_evt;
    irq_set[IRQ_PG_TMO_BIT]  = |(pers_exp & ~pers_d1_q);
    irq_set[IRQ_UV_WARN_BIT] = uvw_s && !uvw_d1_q;
    irq_set[IRQ_UV_STBY_BIT] = uv_s && !uv_d1_q;
    irq_set[IRQ_OT_WARN_BIT] = otw_s && !otw_d1_q;
    irq_set[IRQ_OT_STBY_BIT] = ot_fault_q && !ot_d1_q;
  end

  // sticky status: mask never stops the set; set wins over clear
  logic [7:0] irq_stat_q;
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_stat_q <= IRQ_STATUS_RST;
    end else if (clr_hit) begin
      irq_stat_q <= irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  // interrupt pin: any unmasked latched event holds it low
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_n_out <= 1'b1;
    end else begin
      irq_n_out <= ~|(irq_set_or_stat() & ~irq_mask_q & IRQ_PIN_BITS);
    end
  end

  // latched bits as they stand after this cycle's update
  function automatic logic [7:0] irq_set_or_stat();
    irq_set_or_stat = clr_hit ? irq_set : (irq_stat_q | irq_set);
  endfunction

  // startup timeout on rising supply
  logic rise_seen_q;   // supply has crossed rising level
  logic startup_exp;   // timeout elapsed without rise
  logic inhibit_q;     // enables inhibited by timeout

  fsim_interval_timer #(.LIMIT(STARTUP_LIM)) u_startup (
    .clk_in      (sys_clk_in),
    .arst_n_in   (arst_n_in),
    .tick_in     (tick_q),
    .cond_in     (!rise_seen_q),
    .expired_out (startup_exp)
  );

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rise_seen_q <= 1'b0;
      inhibit_q   <= 1'b0;
    end else begin
      if (rise_s) begin
        rise_seen_q <= 1'b1;
      end
      if (startup_exp && !rise_s) begin
        inhibit_q <= 1'b1;
      end
    end
  end

  // operating state controller
  fsim_state_type   state_q;     // current state
  logic [CNT_W-1:0] st_cnt_q;    // ticks in timed state
  logic             pwr_held_q;  // power-on high throughout standby
  logic             fault;       // any standby-forcing fault

  assign fault    = uv_s || ot_fault_q;
  assign hard_reset_command_evt = hard_reset_command_hit;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q    <= ST_POR;
      st_cnt_q   <= '0;
      pwr_held_q <= 1'b0;
    end else if (hard_reset_command_evt) begin
      state_q    <= ST_HARD_RESET_COMMAND_WAIT;
      st_cnt_q   <= '0;
      pwr_held_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_POR: begin
          if (pwr_s && !fault && !inhibit_q) begin
            state_q <= ST_ON;
          end
        end
        ST_ON: begin
          if (fault) begin
            state_q    <= ST_STANDBY;
            st_cnt_q   <= '0;
            pwr_held_q <= 1'b1;
          end else if (!pwr_s) begin
            state_q <= ST_POR;
          end
        end
        ST_STANDBY: begin
          if (!pwr_s) begin
            pwr_held_q <= 1'b0;
          end
          if (st_cnt_q >= CNT_W'(STANDBY_LIM)) begin
            st_cnt_q <= '0;
            state_q  <= (pwr_held_q && pwr_s && !fault) ? ST_ON : ST_POR;
          end else if (tick_q) begin
            st_cnt_q <= st_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        ST_HARD_RESET_COMMAND_WAIT: begin
          if (st_cnt_q >= CNT_W'(HARD_RESET_COMMAND_LIM)) begin
            st_cnt_q <= '0;
            state_q  <= ST_POR;
          end else if (tick_q) begin
            st_cnt_q <= st_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
      endcase
    end
  end

  // registered controller outputs
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_out           <= ST_POR;
      enables_inhibit_out <= 1'b0;
      keepalive_clear_out <= 1'b0;
      cmd_defaults_out    <= 1'b0;
    end else begin
      state_out           <= state_q;
      enables_inhibit_out <= inhibit_q;
      keepalive_clear_out <= hard_reset_command_evt || ((state_q == ST_ON) && fault);
      cmd_defaults_out    <= hard_reset_command_evt;
    end
  end

  // register read data, registered
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= READ_UNMAPPED;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_WARN_CTRL:  reg_rdata_out <= ctrl_q;
        ADDR_PG_LATCHED: reg_rdata_out <= pg_latched;
        ADDR_PG_LIVE:    reg_rdata_out <= pg_live;
        ADDR_PG_MASK:    reg_rdata_out <= pg_mask_q;
        ADDR_IRQ_STATUS: reg_rdata_out <= irq_stat_q;
        ADDR_IRQ_MASK:   reg_rdata_out <= irq_mask_q;
        default:         reg_rdata_out <= READ_UNMAPPED;
      endcase
    end
  end

endmodule

// *** verif/fsim_host.sv ***
/* host model: register strobes of the serial command engine.
   assumes the bench clock; strobes move on falling edges. */
`timescale 1ns/10ps
module fsim_host (
  // clock and read data
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  // strobes {cmd, rd, wr}, address, data
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic      [2:0] strb_out
);
  initial {strb_out, addr_out, wdata_out} = 19'h0;
  // one-cycle access, then the bus shows inverted junk
  task automatic acc(input logic [2:0] k, input logic [7:0] a, d);
    @(negedge clk_in);
    {strb_out, addr_out, wdata_out} = {k, a, d};
    @(negedge clk_in);
    {strb_out, addr_out, wdata_out} = {3'h0, ~a, ~d};
  endtask
  // read data has settled one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    acc(3'h2, a, 8'h00);
    @(negedge clk_in);
    d = rdata_in;
  endtask
endmodule

// *** verif/fsim_monitor_sva.sv ***
/* port checker of the monitor.
   assumes one clock domain; bound below. */
`timescale 1ns/10ps
module fsim_sva
  import fsim_pkg::*;
(
  input wire logic           sys_clk_in,
  input wire logic           arst_n_in,
  input wire logic [7:0]     reg_addr_in,
  input wire logic           reg_wr_in,
  input wire logic [7:0]     reg_wdata_in,
  input wire logic           reg_rd_in,
  input wire logic           reg_cmd_in,
  input wire logic [7:0]     reg_enabled_in,
  input wire logic [2:0]     uv_warn_sel_out,
  input wire logic [1:0]     ot_warn_sel_out,
  input wire logic           power_good_output_o_out,
  input wire logic           power_good_output_oe_out,
  input wire logic           irq_n_out,
  input wire fsim_state_type state_out,
  input wire logic           enables_inhibit_out,
  input wire logic           keepalive_clear_out,
  input wire logic           cmd_defaults_out
);
  // decoded accesses
  wire clr = (reg_wr_in | reg_rd_in | reg_cmd_in) && reg_addr_in == ADDR_IRQ_CLEAR;
  wire hr = (reg_wr_in | reg_cmd_in) && reg_addr_in == ADDR_HARD_RESET;
  wire cw = reg_wr_in && reg_addr_in == ADDR_WARN_CTRL;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  chk_od_low: assert property (!power_good_output_o_out)
    else $error("pg pin driven high");
  chk_pg_off: assert property (
    (reg_enabled_in == 8'h00) [*5] |-> power_good_output_oe_out) else $error("pg not low");
  chk_uv_sel: assert property (
    cw |=> uv_warn_sel_out == $past(reg_wdata_in[4:2])) else $error("uv select");
  chk_ot_sel: assert property (
    cw |=> ot_warn_sel_out == $past(reg_wdata_in[1:0])) else $error("ot select");
  chk_irq_rel: assert property ($rose(irq_n_out) |-> $past(clr))
    else $error("irq released without clear");
  chk_hr_state: assert property (hr |-> ##[1:4] state_out == ST_HARD_RESET_COMMAND_WAIT)
    else $error("no hard reset wait");
  chk_hr_dflt: assert property (
    hr |-> ##[1:4] cmd_defaults_out && keepalive_clear_out) else $error("no defaults");
  chk_hr_irq: assert property (hr |-> ##3 !irq_n_out)
    else $error("hard reset irq");
  chk_inh_hold: assert property (enables_inhibit_out |=> enables_inhibit_out)
    else $error("inhibit dropped");
  cover property (state_out == ST_STANDBY);
  cover property (!irq_n_out);
  cover property (enables_inhibit_out);
endmodule
bind fsim_monitor fsim_sva i_sva (.sys_clk_in, .arst_n_in, .reg_addr_in, .reg_wr_in,
  .reg_wdata_in, .reg_rd_in, .reg_cmd_in, .reg_enabled_in, .uv_warn_sel_out,
  .ot_warn_sel_out, .power_good_output_o_out, .power_good_output_oe_out, .irq_n_out,
  .state_out, .enables_inhibit_out, .keepalive_clear_out, .cmd_defaults_out);

// *** verif/testbench.sv ***
/* bench for the monitor: register accesses and comparator stimulus.
   assumes shortened interval parameters and a 100 MHz clock. */
`timescale 1ns/10ps
module testbench
  import fsim_pkg::*;
();
  logic clk = 0, rst_n = 0, oe, inh, irq_n, uv = 0, rok = 1, od, ka, cd;
  logic uw = 0, ot = 0, cool = 1, ow = 0, pon = 1;
  logic [7:0] a, wd, rdat, en = 0, lo = 0, gd = 0, d;
  logic [2:0] s, uvs;
  logic [1:0] ots;
  fsim_state_type st;
  int n_mismatch = 0, samples_checked = 0;
  fsim_host i_host (.clk_in(clk), .rdata_in(rdat), .addr_out(a), .wdata_out(wd), .strb_out(s));
  fsim_monitor #(.FILTER_LIM(4), .PERSIST_LIM(20), .HOLD_LIM(8), .STARTUP_LIM(50),
    .STANDBY_LIM(10), .HARD_RESET_COMMAND_LIM(10)) i_dut (.sys_clk_in(clk), .arst_n_in(rst_n),
    .reg_addr_in(a), .reg_wr_in(s[0]), .reg_wdata_in(wd), .reg_rd_in(s[1]),
    .reg_cmd_in(s[2]), .reg_rdata_out(rdat), .reg_enabled_in(en), .reg_out_low_in(lo),
    .reg_out_good_in(gd), .supply_undervoltage_in(uv), .supply_rise_ok_in(rok),
    .supply_uv_warn_in(uw), .die_overtemperature_in(ot), .die_ot_recovered_in(cool),
    .die_ot_warn_in(ow), .master_power_on_input_in(pon), .uv_warn_sel_out(uvs),
    .ot_warn_sel_out(ots), .power_good_output_o_out(od), .power_good_output_oe_out(oe),
    .irq_n_out(irq_n), .state_out(st), .enables_inhibit_out(inh),
    .keepalive_clear_out(ka), .cmd_defaults_out(cd));
  initial forever #5 clk = ~clk;
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input logic [7:0] g, e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task rchk(input logic [7:0] ad, e, m = 8'hff);
    i_host.rd(ad, d);
    chk(d & m, e);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait for the interrupt pin
  task wirq(input int n);
    while (irq_n !== 1'b0 && n > 0) begin
      cyc(1);
      n--;
    end
    chk(irq_n, 1'b0);
    if (irq_n !== 1'b0) give_verdict;
  endtask
  initial begin
    cyc(20);
    rst_n = 1;
    cyc(2);
    rchk(ADDR_WARN_CTRL, 8'h00);
    rchk(ADDR_PG_MASK, 8'hef);
    rchk(8'h08, 8'h00);
    i_host.acc(3'h1, ADDR_PG_MASK, 8'hff);
    rchk(ADDR_PG_MASK, 8'hef);
    i_host.acc(3'h1, ADDR_IRQ_MASK, 8'hff);
    rchk(ADDR_IRQ_MASK, 8'h7c);
    i_host.acc(3'h1, ADDR_WARN_CTRL, 8'h1d);
    chk({3'h0, uvs, ots}, 8'h1d);
    i_host.acc(3'h1, ADDR_IRQ_MASK, 8'h10);
    i_host.acc(3'h1, ADDR_PG_MASK, 8'hed);
    en = 8'hef;
    gd = 8'hef;
    cyc(10);
    chk(oe, 1'b0);
    chk(od, 1'b0);
    lo = 8'h03;
    cyc(150);
    lo = 8'h00;
    cyc(10);
    chk(oe, 1'b0);
    lo = 8'h03;
    wirq(3000);
    chk(oe, 1'b1);
    rchk(ADDR_IRQ_STATUS, 8'h04);
    rchk(ADDR_PG_LIVE, 8'hec, PG_USED_MASK);
    lo = 8'h00;
    cyc(300);
    chk(oe, 1'b1);
    rchk(ADDR_PG_LATCHED, 8'hec, PG_USED_MASK);
    cyc(1500);
    chk(oe, 1'b0);
    i_host.acc(3'h4, ADDR_IRQ_CLEAR, 8'h00);
    chk(irq_n, 1'b1);
    uv = 1;
    cyc(8);
    uv = 0;
    cyc(4);
    chk(st, ST_STANDBY);
    rchk(ADDR_IRQ_STATUS, 8'h10);
    chk(irq_n, 1'b1);
    cyc(1100);
    chk(st, ST_ON);
    i_host.acc(3'h4, ADDR_HARD_RESET, 8'h00);
    rchk(ADDR_IRQ_MASK, 8'h00);
    chk(st, ST_HARD_RESET_COMMAND_WAIT);
    rchk(ADDR_IRQ_STATUS, 8'h12);
    chk(irq_n, 1'b0);
    i_host.acc(3'h1, ADDR_IRQ_CLEAR, 8'h00);
    chk(irq_n, 1'b1);
    cyc(1100);
    chk(st, ST_ON);
    uw = 1;
    ow = 1;
    ot = 1;
    cool = 0;
    cyc(6);
    ot = 0;
    cyc(6);
    chk(st, ST_STANDBY);
    chk(irq_n, 1'b0);
    rchk(ADDR_IRQ_STATUS, 8'h68);
    cyc(1100);
    chk(st, ST_POR);
    cool = 1;
    cyc(6);
    chk(st, ST_ON);
    pon = 0;
    cyc(6);
    chk(st, ST_POR);
    rst_n = 0;
    rok = 0;
    cyc(2);
    rst_n = 1;
    cyc(5300);
    chk(inh, 1'b1);
    give_verdict;
  end
endmodule
